// *** hdl/eeh_map.vh ***
// Purpose: Constants of the parallel port host handshake block.
// Assumes: System clock of 10 MHz.
// Notes:   Times are in ns; cycle counts derive from them.
`ifndef EEH_MAP_VH
`define EEH_MAP_VH

// ==========================================================
// Clock
`define EEH_CLK_NS          100

// ==========================================================
// Port modes on i_mode
`define EEH_MODE_FIFO       3'h5
`define EEH_MODE_ECP        3'h3
`define EEH_MODE_EPP        3'h4

// ==========================================================
// Timing, least times rounded up to whole cycles
`define EEH_FIFO_SETUP_NS   600
`define EEH_FIFO_PULSE_NS   600
`define EEH_ECP_SETUP_NS    80
`define EEH_WAIT_FILT_NS    50
`define EEH_CYC_UP(t)       (((t) + `EEH_CLK_NS - 1) / `EEH_CLK_NS)
`define EEH_FIFO_SETUP_CYC  `EEH_CYC_UP(`EEH_FIFO_SETUP_NS)
`define EEH_FIFO_PULSE_CYC  `EEH_CYC_UP(`EEH_FIFO_PULSE_NS)
`define EEH_ECP_SETUP_CYC   `EEH_CYC_UP(`EEH_ECP_SETUP_NS)
`define EEH_WAIT_FILT_CYC   `EEH_CYC_UP(`EEH_WAIT_FILT_NS)

// ==========================================================
// Widths and reset values
`define EEH_CNT_W           4
`define EEH_SYNC_W          12
`define EEH_SYNC_RST        12'hfff

`endif

// *** hdl/eeh_sync.v ***
// Purpose: Two-stage synchronizer for a group of asynchronous inputs.
// Assumes: Each bit is a level; no bus coherence is promised.
// Notes:   The first stage is read only by the second.
module eeh_sync
#(
  parameter         W   = 12,
  parameter [W-1:0] RST = {W{1'b1}}
)
(
  // Clock and reset
  input  wire         i_clk_sys,
  input  wire         i_arst_n,
  input  wire         i_clk_en,
  // Data
  input  wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);

  reg [W-1:0] stage1;
  reg [W-1:0] stage2;

  // ========================================================
  // Synchronizer bits
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1)
    begin : g_bit
      always @(posedge i_clk_sys or negedge i_arst_n)
      begin
        if (!i_arst_n)
        begin
          stage1[g] <= RST[g];
          stage2[g] <= RST[g];
        end
        else if (i_clk_en)
        begin
          stage1[g] <= i_async[g];
          stage2[g] <= stage1[g];
        end
      end
    end
  endgenerate

  assign o_sync = stage2;

endmodule // eeh_sync

// *** hdl/eeh_filter.v ***
// Purpose: Glitch filter that accepts a level only once it is stable.
// Assumes: Input is already synchronized.
// Notes:   N is the number of cycles without a transition.
module eeh_filter
#(
  parameter N = 1
)
(
  // Clock and reset
  input  wire i_clk_sys,
  input  wire i_arst_n,
  input  wire i_clk_en,
  // Data
  input  wire i_level,
  output reg  o_level
);

`include "eeh_map.vh"

  localparam integer          I_N = N;
  localparam [`EEH_CNT_W-1:0] L_N = I_N[`EEH_CNT_W-1:0];

  reg                  prev;
  reg [`EEH_CNT_W-1:0] stable;

  // ========================================================
  // Stability counter
  always @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      prev    <= 1'b1;
      stable  <= {`EEH_CNT_W{1'b0}};
      o_level <= 1'b1;
    end
    else if (i_clk_en)
    begin
      prev <= i_level;
      if (i_level != prev)
        stable <= {`EEH_CNT_W{1'b0}};
      else if (stable != L_N)
        stable <= stable + 1'b1;
      if (i_level == prev && stable + 1'b1 >= L_N)
        o_level <= i_level;
    end
  end

endmodule // eeh_filter

// *** hdl/eeh_host.v ***
// Purpose: Host handshake of a multi-mode parallel port (FIFO, ECP, EPP).
// Assumes: Cable inputs are asynchronous; user streams are synchronous.
// Notes:   Mode should only change while o_idle is high.
// Operation
// - FIFO mode paces bytes on Busy, ignores nACK
// - Forward idle holds strobe high
// - Forward byte starts only from forward idle
// - Strobe low after Busy low, data set up
// - Strobe high only after Busy seen high
// - Reverse idle holds nALF low
// - nALF low only after previous byte accepted
// - nALF high when byte taken, after nACK seen low
// - nALF low again after byte captured
// - Wait input filtered for 50 ns stability
// - Write output high outside write cycles
module eeh_host
(
  // Clock, reset and enable
  input  wire       i_clk_sys,
  input  wire       i_arst_n,
  input  wire       i_clk_en,
  // Mode
  input  wire [2:0] i_mode,
  input  wire       i_ecp_reverse,
  // Forward byte stream
  input  wire [7:0] i_fwd_data,
  input  wire       i_fwd_valid,
  output wire       o_fwd_ready,
  // Reverse byte stream
  output reg  [7:0] o_rev_data,
  output reg        o_rev_valid,
  input  wire       i_rev_ready,
  // Cable inputs
  input  wire       i_busy,
  input  wire       i_nack,
  input  wire       i_nfault,
  input  wire       i_nwait,
  input  wire [7:0] i_pd_in,
  // Cable outputs
  output reg  [7:0] o_pd_out,
  output reg        o_pd_oe_n,
  output reg        o_nstrobe,
  output reg        o_nalf,
  output reg        o_nwrite,
  // Status
  output wire       o_periph_req,
  output wire       o_wait_level,
  output wire       o_idle
);

`include "eeh_map.vh"

  localparam [3:0] S_IDLE  = 4'h0;
  localparam [3:0] S_SETUP = 4'h1;
  localparam [3:0] S_STRB  = 4'h2;
  localparam [3:0] S_REL   = 4'h3;
  localparam [3:0] S_RACK  = 4'h4;
  localparam [3:0] S_EWR   = 4'h5;
  localparam [3:0] S_ECMD  = 4'h6;

  localparam integer          I_FIFO_SETUP = `EEH_FIFO_SETUP_CYC;
  localparam integer          I_FIFO_PULSE = `EEH_FIFO_PULSE_CYC;
  localparam integer          I_ECP_SETUP  = `EEH_ECP_SETUP_CYC;
  localparam [`EEH_CNT_W-1:0] L_FIFO_SETUP = I_FIFO_SETUP[`EEH_CNT_W-1:0];
  localparam [`EEH_CNT_W-1:0] L_FIFO_PULSE = I_FIFO_PULSE[`EEH_CNT_W-1:0];
  localparam [`EEH_CNT_W-1:0] L_ECP_SETUP  = I_ECP_SETUP[`EEH_CNT_W-1:0];

  reg  [3:0]            state;
  reg  [3:0]            next_state;
  reg  [`EEH_CNT_W-1:0] cnt;
  reg  [`EEH_CNT_W-1:0] setup_len;

  wire [`EEH_SYNC_W-1:0] sync_bus;
  wire [7:0]             pd_s;
  wire                   busy_s;
  wire                   nack_s;
  wire                   nfault_s;
  wire                   nwait_s;
  wire                   mode_fifo;
  wire                   mode_ecp_f;
  wire                   mode_ecp_r;
  wire                   mode_epp;
  wire                   fwd_take;
  wire                   rev_take;

  // ========================================================
  // Input synchronization and wait filter
  eeh_sync
  #(
    .W   (`EEH_SYNC_W),
    .RST (`EEH_SYNC_RST)
  )
  u_sync
  (
    .i_clk_sys (i_clk_sys),
    .i_arst_n  (i_arst_n),
    .i_clk_en  (i_clk_en),
    .i_async   ({i_busy, i_nack, i_nfault, i_nwait, i_pd_in}),
    .o_sync    (sync_bus)
  );

  assign busy_s   = sync_bus[11];
  assign nack_s   = sync_bus[10];
  assign nfault_s = sync_bus[9];
  assign pd_s     = sync_bus[7:0];

  eeh_filter
  #(
    .N (`EEH_WAIT_FILT_CYC)
  )
  u_wait_filter
  (
    .i_clk_sys (i_clk_sys),
    .i_arst_n  (i_arst_n),
    .i_clk_en  (i_clk_en),
    .i_level   (sync_bus[8]),
    .o_level   (nwait_s)
  );

  assign o_wait_level = nwait_s;
  // A low nFault in forward ECP asks for the channel to be reversed.
  assign o_periph_req = mode_ecp_f & ~nfault_s;

  // ========================================================
  // Mode decode and stream handshakes
  assign mode_fifo  = (i_mode == `EEH_MODE_FIFO);
  assign mode_ecp_f = (i_mode == `EEH_MODE_ECP) & ~i_ecp_reverse;
  assign mode_ecp_r = (i_mode == `EEH_MODE_ECP) & i_ecp_reverse;
  assign mode_epp   = (i_mode == `EEH_MODE_EPP);

  // Forward bytes start only from idle, with Busy low in FIFO and ECP and nWait high in EPP.
  assign o_fwd_ready = (state == S_IDLE) &
                       (((mode_fifo | mode_ecp_f) & ~busy_s) |
                        (mode_epp & nwait_s));
  assign fwd_take    = o_fwd_ready & i_fwd_valid;
  // A reverse byte is taken once nACK is low and the user can accept it.
  assign rev_take    = (state == S_IDLE) & mode_ecp_r & ~nack_s &
                       i_rev_ready;
  assign o_idle      = (state == S_IDLE);

  // ========================================================
  // Next state
  always @*
  begin
    next_state = state;
    case (state)
      S_IDLE:
      begin
        if (fwd_take & mode_epp)
          next_state = S_EWR;
        else if (fwd_take)
          next_state = S_SETUP;
        else if (rev_take)
          next_state = S_RACK;
      end
      S_SETUP:
      begin
        if (cnt >= setup_len)
          next_state = S_STRB;
      end
      S_STRB:
      begin
        // Strobe is released only after Busy is seen high.
        if (busy_s & (~mode_fifo | cnt >= L_FIFO_PULSE))
          next_state = S_REL;
      end
      S_REL:
      begin
        // Busy falling ends the byte; nACK is never examined.
        if (~busy_s)
          next_state = S_IDLE;
      end
      S_RACK:
      begin
        if (nack_s)
          next_state = S_IDLE;
      end
      S_EWR:
      begin
        if (~nwait_s)
          next_state = S_ECMD;
      end
      S_ECMD:
      begin
        if (nwait_s)
          next_state = S_IDLE;
      end
      default:
        next_state = S_IDLE;
    endcase
  end

  // ========================================================
  // State, counter and cable outputs
  always @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state       <= S_IDLE;
      cnt         <= {`EEH_CNT_W{1'b0}};
      setup_len   <= {`EEH_CNT_W{1'b0}};
      o_pd_out    <= 8'h00;
      o_pd_oe_n   <= 1'b1;
      o_nstrobe   <= 1'b1;
      o_nalf      <= 1'b0;
      o_nwrite    <= 1'b1;
      o_rev_data  <= 8'h00;
      o_rev_valid <= 1'b0;
    end
    else if (i_clk_en)
    begin
      state       <= next_state;
      o_rev_valid <= 1'b0;
      if (next_state != state)
        cnt <= {`EEH_CNT_W{1'b0}};
      else if (cnt != {`EEH_CNT_W{1'b1}})
        cnt <= cnt + 1'b1;
      // The data pins are driven in forward modes only.
      o_pd_oe_n <= ~(mode_fifo | mode_ecp_f | (mode_epp & state != S_IDLE));
      case (state)
        S_IDLE:
        begin
          o_nstrobe <= 1'b1;
          o_nwrite  <= 1'b1;
          o_nalf    <= 1'b0;
          if (fwd_take)
          begin
            o_pd_out  <= i_fwd_data;
            setup_len <= mode_fifo ? L_FIFO_SETUP : L_ECP_SETUP;
          end
          if (fwd_take & mode_epp)
            o_nwrite <= 1'b0;
          if (rev_take)
          begin
            o_rev_data  <= pd_s;
            o_rev_valid <= 1'b1;
            o_nalf      <= 1'b1;
          end
        end
        S_SETUP:
        begin
          // Data has stood for the setup time before the strobe falls.
          if (next_state == S_STRB)
            o_nstrobe <= 1'b0;
        end
        S_STRB:
        begin
          if (next_state == S_REL)
            o_nstrobe <= 1'b1;
        end
        S_RACK:
        begin
          // The byte was captured; nALF falls once nACK is back high.
          if (next_state == S_IDLE)
            o_nalf <= 1'b0;
        end
        S_EWR:
        begin
          if (next_state == S_ECMD)
            o_nstrobe <= 1'b0;
        end
        S_ECMD:
        begin
          if (next_state == S_IDLE)
          begin
            o_nstrobe <= 1'b1;
            o_nwrite  <= 1'b1;
          end
        end
        default:
        begin
          o_nstrobe <= 1'b1;
          o_nwrite  <= 1'b1;
        end
      endcase
    end
  end

endmodule // eeh_host

// *** test/eeh_host_asserts.sv ***
// Purpose: Port checks of the parallel port host handshake.
// Assumes: Clock enable held high.
// Notes:   Bound to every eeh_host.
`include "eeh_map.vh"
module eeh_host_chk
(
  // Clock and reset
  input wire       i_clk_sys,
  input wire       i_arst_n,
  // Inputs
  input wire [2:0] i_mode,
  input wire       i_fwd_valid,
  input wire       i_rev_ready,
  input wire       i_busy,
  input wire       i_nack,
  input wire       i_nwait,
  // Outputs
  input wire       o_fwd_ready,
  input wire       o_rev_valid,
  input wire       o_nstrobe,
  input wire       o_nalf,
  input wire       o_nwrite,
  input wire       o_wait_level,
  input wire       o_idle
);
  timeunit 1ns;
  timeprecision 1ns;
  wire take = o_fwd_ready && i_fwd_valid;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  property p_idle_str; o_idle |-> o_nstrobe; endproperty
  a_idle_str: assert property (p_idle_str)
    else $error("strobe low in idle");
  property p_idle_wr; o_idle |-> o_nwrite; endproperty
  a_idle_wr: assert property (p_idle_wr)
    else $error("write low in idle");
  property p_rdy_idle; o_fwd_ready |-> o_idle; endproperty
  a_rdy_idle: assert property (p_rdy_idle)
    else $error("ready outside idle");
  property p_fifo_lat;
    take && i_mode == `EEH_MODE_FIFO |-> o_nstrobe[*8] ##[1:2] !o_nstrobe;
  endproperty
  a_fifo_lat: assert property (p_fifo_lat)
    else $error("fifo strobe timing");
  property p_ecp_lat;
    take && i_mode == `EEH_MODE_ECP |-> o_nstrobe[*3] ##[1:2] !o_nstrobe;
  endproperty
  a_ecp_lat: assert property (p_ecp_lat)
    else $error("ecp strobe timing");
  property p_str_up;
    $rose(o_nstrobe) && i_mode != `EEH_MODE_EPP
      |-> $past(i_busy, 3) || $past(i_busy, 4);
  endproperty
  a_str_up: assert property (p_str_up)
    else $error("strobe up without busy");
  property p_ack_up; $rose(o_nalf) |-> o_rev_valid && $past(i_rev_ready);
  endproperty
  a_ack_up: assert property (p_ack_up)
    else $error("ack up without capture");
  property p_ack_dn; $fell(o_nalf) |-> $past(i_nack, 3) || $past(i_nack, 4);
  endproperty
  a_ack_dn: assert property (p_ack_dn)
    else $error("ack down before release");
  property p_wait_flt;
    $changed(o_wait_level) |-> $past(i_nwait, 3) == o_wait_level
      && $past(i_nwait, 4) == o_wait_level;
  endproperty
  a_wait_flt: assert property (p_wait_flt)
    else $error("wait level taken unsettled");
  c_fifo: cover property (take && i_mode == `EEH_MODE_FIFO);
  c_rev: cover property (o_rev_valid);
  c_epp: cover property ($fell(o_nwrite));
endmodule // eeh_host_chk

bind eeh_host eeh_host_chk eeh_host_chk_i (.i_clk_sys, .i_arst_n, .i_mode,
  .i_fwd_valid, .i_rev_ready, .i_busy, .i_nack, .i_nwait, .o_fwd_ready,
  .o_rev_valid, .o_nstrobe, .o_nalf, .o_nwrite, .o_wait_level, .o_idle);

// *** test/eeh_periph.sv ***
// Purpose: Cable peripheral model for the host handshake.
// Assumes: Replies a set number of clock cycles after each host edge.
// Notes:   Released data lines show the inverse of the byte.
module eeh_periph
(
  // Control
  input  wire       i_clk_sys,
  input  wire [3:0] i_dly,
  input  wire       i_go,
  input  wire       i_glitch,
  input  wire [7:0] i_byte,
  // Host side
  input  wire       i_nstrobe,
  input  wire       i_nalf,
  input  wire       i_nwrite,
  output wire [7:0] o_pd,
  output reg        o_busy,
  output reg        o_nack,
  output wire       o_nwait
);
  timeunit 1ns;
  timeprecision 1ns;
  reg drv;
  reg nwait;
  task automatic hold;
    repeat (i_dly) @(posedge i_clk_sys);
    #3;
  endtask
  initial
  begin
    o_busy = 1'b0;
    o_nack = 1'b1;
    drv = 1'b0;
    nwait = 1'b1;
  end
  always
  begin
    @(negedge i_nstrobe);
    hold;
    o_busy = 1'b1;
    @(posedge i_nstrobe);
    hold;
    o_busy = 1'b0;
  end
  always
  begin
    wait (i_go && i_nalf === 1'b0 && o_nack);
    hold;
    drv = 1'b1;
    hold;
    o_nack = 1'b0;
    @(posedge i_nalf);
    hold;
    o_nack = 1'b1;
    drv = 1'b0;
  end
  always
  begin
    @(negedge i_nwrite);
    hold;
    nwait = 1'b0;
    @(negedge i_nstrobe);
    hold;
    nwait = 1'b1;
  end
  assign o_nwait = nwait ^ i_glitch;
  assign o_pd = drv ? i_byte : ~i_byte;
endmodule // eeh_periph

// *** test/tb_top.sv ***
// Purpose: Self-checking bench of the parallel port host handshake.
// Assumes: Clock enable tied high.
// Notes:   Nothing is random.
`include "eeh_map.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk_sys = 1'b0, i_arst_n = 1'b0, i_ecp_reverse = 1'b0;
  logic i_fwd_valid = 1'b0, i_rev_ready = 1'b0, i_nfault = 1'b1;
  logic go = 1'b0, glitch = 1'b0;
  logic [2:0] i_mode = 3'h0;
  logic [3:0] dly = 4'h2;
  logic [7:0] i_fwd_data = 8'h00, pbyte = 8'h96;
  wire [7:0] o_rev_data, o_pd_out, pd;
  wire o_fwd_ready, o_rev_valid, busy, nack, nwait, o_pd_oe_n, o_nstrobe;
  wire o_nalf, o_nwrite, o_periph_req, o_wait_level, o_idle;
  int n_fail = 0, total_checks = 0, cyc = 0, n;
  eeh_host eeh_host_i (.i_clk_sys, .i_arst_n, .i_clk_en(1'b1), .i_mode,
    .i_ecp_reverse, .i_fwd_data, .i_fwd_valid, .o_fwd_ready, .o_rev_data,
    .o_rev_valid, .i_rev_ready, .i_busy(busy), .i_nack(nack), .i_nfault,
    .i_nwait(nwait), .i_pd_in(pd), .o_pd_out, .o_pd_oe_n, .o_nstrobe,
    .o_nalf, .o_nwrite, .o_periph_req, .o_wait_level, .o_idle);
  eeh_periph eeh_periph_i (.i_clk_sys, .i_dly(dly), .i_go(go),
    .i_glitch(glitch), .i_byte(pbyte), .i_nstrobe(o_nstrobe),
    .i_nalf(o_nalf), .i_nwrite(o_nwrite), .o_pd(pd), .o_busy(busy),
    .o_nack(nack), .o_nwait(nwait));
  initial
    forever #50 i_clk_sys = ~i_clk_sys;
  task end_sim;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge i_clk_sys)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_fail++;
      end_sim;
    end
  end
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task step;
    @(posedge i_clk_sys);
    #5;
  endtask
  task to_idle;
    for (n = 0; n < 80 && o_idle !== 1'b1; n++) step;
  endtask
  task send(input logic [7:0] b, input int lat);
    i_fwd_data = b;
    i_fwd_valid = 1'b1;
    for (n = 0; n < 80 && o_fwd_ready !== 1'b1; n++) step;
    step;
    i_fwd_valid = 1'b0;
    chk("pd_out", b, o_pd_out);
    for (n = 0; n < 80 && o_nstrobe !== 1'b0; n++) step;
    chk("strobe delay", lat, n);
  endtask
  task t_reset;
    chk("rst nstrobe", 1, o_nstrobe);
    chk("rst nalf", 0, o_nalf);
    chk("rst nwrite", 1, o_nwrite);
  endtask
  task t_fifo;
    go = 1'b1;
    i_mode = `EEH_MODE_FIFO;
    send(8'ha5, 7);
    send(8'h3c, 7);
    to_idle;
    chk("idle nstrobe", 1, o_nstrobe);
    chk("fifo pd oe", 0, o_pd_oe_n);
  endtask
  task t_ecp;
    i_mode = `EEH_MODE_ECP;
    i_nfault = 1'b0;
    send(8'h81, 2);
    chk("periph req", 1, o_periph_req);
    i_nfault = 1'b1;
    to_idle;
    chk("periph req off", 0, o_periph_req);
  endtask
  task t_rev;
    i_ecp_reverse = 1'b1;
    repeat (8) step;
    chk("stall nalf", 0, o_nalf);
    chk("rev pd oe", 1, o_pd_oe_n);
    i_rev_ready = 1'b1;
    for (n = 0; n < 80 && o_rev_valid !== 1'b1; n++) step;
    chk("rev byte", 8'h96, o_rev_data);
    pbyte = 8'h5a;
    dly = 4'h5;
    step;
    for (n = 0; n < 80 && o_rev_valid !== 1'b1; n++) step;
    chk("rev byte 2", 8'h5a, o_rev_data);
    go = 1'b0;
    for (n = 0; n < 80 && o_nalf !== 1'b0; n++) step;
    chk("rev idle nalf", 0, o_nalf);
    i_ecp_reverse = 1'b0;
    to_idle;
  endtask
  task t_epp;
    i_mode = `EEH_MODE_EPP;
    dly = 4'h1;
    i_fwd_data = 8'hc3;
    i_fwd_valid = 1'b1;
    for (n = 0; n < 80 && o_fwd_ready !== 1'b1; n++) step;
    step;
    i_fwd_valid = 1'b0;
    for (n = 0; n < 80 && o_nstrobe !== 1'b0; n++) step;
    chk("epp nwrite", 0, o_nwrite);
    chk("epp data", 8'hc3, o_pd_out);
    for (n = 0; n < 80 && o_nwrite !== 1'b1; n++) step;
    chk("epp strobe", 1, o_nstrobe);
    glitch = 1'b1;
    step;
    glitch = 1'b0;
    repeat (4) step;
    chk("wait glitch", 1, o_wait_level);
    glitch = 1'b1;
    repeat (5) step;
    chk("wait settled", 0, o_wait_level);
    glitch = 1'b0;
  endtask
  initial
  begin
    repeat (15) step;
    t_reset;
    step;
    i_arst_n = 1'b1;
    repeat (3) step;
    t_fifo;
    t_ecp;
    t_rev;
    t_epp;
    end_sim;
  end
endmodule // tb_top
